//--- hdl/conn_timing_consts.svh
// constants for the connection timing supervisor
`ifndef CONN_TIMING_CONSTS_SVH
`define CONN_TIMING_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS     100
`define MS_PERIOD_NS      1000000
`define CYC_PER_MS        ((`MS_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TMR_RES_MS        1
`define WD_FIRST_MS       10000
`define WD_RATE_MULT      4

// ----------------------------------------
// attribute numbers
// ----------------------------------------
`define ATTR_STATE        8'h01
`define ATTR_PACKET_RATE  8'h09
`define ATTR_TIMEOUT_ACT  8'h0C
`define ATTR_INHIBIT      8'h11

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define RATE_DEFAULT      16'h0000
`define INHIBIT_DEFAULT   16'h0000
`define TOACT_DEFAULT     8'h00
`define TOACT_HOLD        8'h00
`define TOACT_AUTO_DEL    8'h01
`define TOACT_AUTO_RST    8'h02
`define CLASS_2           4'h2
`define CLASS_3           4'h3
`define APPLY_ERR_INHIBIT 32'h0000_0011

`endif

//--- hdl/conn_timing_pkg.sv
// types shared by the connection timing supervisor
package conn_timing_pkg;

    typedef enum logic [3:0] {
        CS_NONE     = 4'b0001,
        CS_CONFIG   = 4'b0010,
        CS_ESTAB    = 4'b0100,
        CS_TIMEDOUT = 4'b1000
    } conn_state_t;

    typedef enum logic [2:0] {
        SVC_GET    = 3'h0,
        SVC_SET    = 3'h1,
        SVC_RESET  = 3'h2,
        SVC_DELETE = 3'h3,
        SVC_APPLY  = 3'h4,
        SVC_CREATE = 3'h5
    } svc_code_t;

    typedef struct packed {
        logic        valid;
        svc_code_t   code;
        logic [7:0]  attr;
        logic [15:0] data;
    } svc_req_t;

    typedef struct packed {
        logic        valid;
        logic        ok;
        logic [31:0] data;
    } svc_rsp_t;

    typedef struct packed {
        logic newData;
        logic retry;
        logic trigger;
        logic blocked;
    } prod_out_t;

endpackage

//--- hdl/ms_tick_gen.sv
// millisecond enable pulse from the system clock
`timescale 1ns/10ps
module ms_tick_gen
    import conn_timing_pkg::*;
#(
    parameter int DIV = 10000
)
(
    input  wire logic clk,
    input  wire logic sys_rst,
    output logic      tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } tick_state_t;

    tick_state_t st;
    tick_state_t next_st;

    always_comb
    begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (st.cnt == CW'(DIV - 1))
        begin
            next_st.cnt  = '0;
            next_st.tick = 1'b1;
        end
        else
            next_st.cnt = st.cnt + CW'(1);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;
endmodule

//--- hdl/conn_ms_timer.sv
// loadable millisecond down-counter with expiry pulse
`timescale 1ns/10ps
module conn_ms_timer
    import conn_timing_pkg::*;
#(
    parameter int W = 18
)
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         tick,
    input  wire logic         load,
    input  wire logic [W-1:0] loadVal,
    input  wire logic         stop,
    output logic [W-1:0]      count,
    output logic              running,
    output logic              expired
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         exp;
    } tmr_state_t;

    tmr_state_t st;
    tmr_state_t next_st;

    // load beats stop beats counting; a load of zero leaves it idle
    always_comb
    begin
        next_st     = st;
        next_st.exp = 1'b0;
        if (load)
            next_st.cnt = loadVal;
        else if (stop)
            next_st.cnt = '0;
        else if (tick && st.cnt != '0)
        begin
            next_st.cnt = st.cnt - W'(1);
            next_st.exp = (st.cnt == W'(1));
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign count   = st.cnt;
    assign running = (st.cnt != '0);
    assign expired = st.exp;
endmodule

//--- hdl/connection_timing_supervisor.sv
// connection timing supervisor: trigger, watchdog and inhibit timers
`timescale 1ns/10ps
`include "conn_timing_consts.svh"

module connection_timing_supervisor
    import conn_timing_pkg::*;
#(
    parameter int CYC_PER_MS = `CYC_PER_MS,
    parameter int WD_W       = 18
)
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        isServer,
    input  wire logic [3:0]  transport_class_select,
    input  wire logic [15:0] outbound_conn_identifier,
    input  wire logic [15:0] inbound_conn_identifier,
    input  wire svc_req_t    svcReq,
    output svc_rsp_t         svcRsp,
    output logic             applyToApp,
    input  wire logic        produceReq,
    input  wire logic        retryReq,
    input  wire logic        consumeValid,
    output prod_out_t        prodOut,
    output logic             rxProcess,
    output logic             timeoutEvent,
    output conn_state_t      connState,
    output logic             inhibitActive
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        conn_state_t conn;
        logic [15:0] rate;
        logic [15:0] gap;
        logic [7:0]  toAct;
        svc_rsp_t    rsp;
        prod_out_t   prod;
        logic        rxProc;
        logic        toEvt;
        logic        applyOut;
    } sup_state_t;

    sup_state_t st;
    sup_state_t next_st;

    logic            tick;
    logic            trigLoad;
    logic            trigStop;
    logic [15:0]     trigVal;
    logic [15:0]     trigCount;
    logic            trigRun;
    logic            trigExp;
    logic            wdLoad;
    logic            wdStop;
    logic [WD_W-1:0] wdVal;
    logic [WD_W-1:0] wdCount;
    logic            wdRun;
    logic            wdExp;
    logic            inhLoad;
    logic            inhStop;
    logic [15:0]     inhCount;
    logic            inhRun;
    logic            consumer;
    logic            newGrant;
    logic [15:0]     setVal;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // round up to the timer grain; saturates at the top of the field
    function automatic logic [15:0] roundUp(input logic [15:0] v);
        logic [16:0] s;
        s = (17'(v) + 17'(`TMR_RES_MS - 1)) / 17'(`TMR_RES_MS);
        s = s * 17'(`TMR_RES_MS);
        roundUp = s[16] ? 16'hFFFF : s[15:0];
    endfunction

    function automatic logic [WD_W-1:0] wdLater(input logic [15:0] r);
        wdLater = WD_W'(r) * WD_W'(`WD_RATE_MULT);
    endfunction

    function automatic logic [WD_W-1:0] wdFirst(input logic [15:0] r);
        logic [WD_W-1:0] m;
        m = wdLater(r);
        wdFirst = (m > WD_W'(`WD_FIRST_MS)) ? m : WD_W'(`WD_FIRST_MS);
    endfunction

    // servers and class 2/3 clients consume
    assign consumer = isServer
                    || transport_class_select == `CLASS_2
                    || transport_class_select == `CLASS_3;

    // ----------------------------------------
    // timers
    // ----------------------------------------
    ms_tick_gen #(.DIV(CYC_PER_MS)) u_tick
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    conn_ms_timer #(.W(16)) u_trig
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick),
        .load    (trigLoad),
        .loadVal (trigVal),
        .stop    (trigStop),
        .count   (trigCount),
        .running (trigRun),
        .expired (trigExp)
    );

    conn_ms_timer #(.W(WD_W)) u_wd
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick),
        .load    (wdLoad),
        .loadVal (wdVal),
        .stop    (wdStop),
        .count   (wdCount),
        .running (wdRun),
        .expired (wdExp)
    );

    conn_ms_timer #(.W(16)) u_inh
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick),
        .load    (inhLoad),
        .loadVal (st.gap),
        .stop    (inhStop),
        .count   (inhCount),
        .running (inhRun),
        .expired ()
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        next_st          = st;
        next_st.rsp      = '0;
        next_st.prod     = '0;
        next_st.rxProc   = 1'b0;
        next_st.toEvt    = 1'b0;
        next_st.applyOut = 1'b0;
        trigLoad = 1'b0;
        trigStop = 1'b0;
        trigVal  = st.rate;
        wdLoad   = 1'b0;
        wdStop   = 1'b0;
        wdVal    = wdLater(st.rate);
        inhLoad  = 1'b0;
        inhStop  = 1'b0;
        setVal   = roundUp(svcReq.data);
        newGrant = produceReq && !inhRun;

        unique case (st.conn)
            CS_NONE,
            CS_CONFIG,
            CS_TIMEDOUT:
            begin
            end
            CS_ESTAB:
            begin
                if (produceReq && inhRun)
                    next_st.prod.blocked = 1'b1;
                if (newGrant)
                begin
                    next_st.prod.newData = 1'b1;
                    trigLoad = 1'b1;
                    // the inhibit timer takes gap only on this load, so a later change waits its turn
                    inhLoad  = !isServer && st.gap != 16'h0000;
                end
                if (retryReq)
                begin
                    next_st.prod.retry = 1'b1;
                    trigLoad = 1'b1;
                end
                if (trigExp && !newGrant && !retryReq)
                begin
                    next_st.prod.trigger = 1'b1;
                    trigLoad = 1'b1;
                end
                if (wdExp)
                begin
                    next_st.toEvt = 1'b1;
                    unique case (st.toAct)
                        `TOACT_AUTO_DEL:
                        begin
                            next_st.conn = CS_NONE;
                            // a same-cycle production must not re-arm a deleted link
                            trigLoad = 1'b0;
                            inhLoad  = 1'b0;
                            trigStop = 1'b1;
                            inhStop  = 1'b1;
                        end
                        `TOACT_AUTO_RST:
                            wdLoad = 1'b1;
                        default:
                            next_st.conn = CS_TIMEDOUT;
                    endcase
                end
                else if (consumeValid && consumer)
                    wdLoad = 1'b1;
                // processing flag rises on the same edge as the restart
                next_st.rxProc = consumeValid;
            end
            default:
                next_st.conn = CS_NONE;
        endcase

        if (svcReq.valid)
        begin
            next_st.rsp.valid = 1'b1;
            if (st.conn == CS_NONE)
            begin
                if (svcReq.code == SVC_CREATE)
                begin
                    next_st.rsp.ok = 1'b1;
                    next_st.conn   = CS_CONFIG;
                    next_st.rate   = `RATE_DEFAULT;
                    next_st.gap    = `INHIBIT_DEFAULT;
                    next_st.toAct  = `TOACT_DEFAULT;
                end
            end
            else
            begin
                unique case (svcReq.code)
                    SVC_GET:
                    begin
                        next_st.rsp.ok = 1'b1;
                        unique case (svcReq.attr)
                            `ATTR_STATE:       next_st.rsp.data = 32'(st.conn);
                            `ATTR_PACKET_RATE: next_st.rsp.data = 32'(st.rate);
                            `ATTR_TIMEOUT_ACT: next_st.rsp.data = 32'(st.toAct);
                            `ATTR_INHIBIT:     next_st.rsp.data = 32'(st.gap);
                            default:           next_st.rsp.ok   = 1'b0;
                        endcase
                    end
                    SVC_SET:
                    begin
                        unique case (svcReq.attr)
                            `ATTR_PACKET_RATE:
                            begin
                                next_st.rsp.ok   = 1'b1;
                                next_st.rsp.data = 32'(setVal);
                                next_st.rate     = setVal;
                                if (st.conn == CS_ESTAB)
                                begin
                                    trigLoad = 1'b1;
                                    trigVal  = setVal;
                                    wdLoad   = consumer && setVal != 16'h0000;
                                    wdStop   = !wdLoad;
                                    wdVal    = wdLater(setVal);
                                end
                            end
                            `ATTR_INHIBIT:
                            begin
                                next_st.rsp.ok   = 1'b1;
                                next_st.rsp.data = 32'(setVal);
                                next_st.gap      = setVal;
                            end
                            `ATTR_TIMEOUT_ACT:
                            begin
                                next_st.rsp.ok = svcReq.data <= 16'(`TOACT_AUTO_RST);
                                if (next_st.rsp.ok)
                                    next_st.toAct = svcReq.data[7:0];
                            end
                            default:
                                next_st.rsp.ok = 1'b0;
                        endcase
                    end
                    SVC_RESET:
                    begin
                        next_st.rsp.ok = 1'b1;
                        if (st.conn == CS_ESTAB || st.conn == CS_TIMEDOUT)
                        begin
                            next_st.conn = CS_ESTAB;
                            wdLoad       = consumer && st.rate != 16'h0000;
                            wdVal        = wdLater(st.rate);
                        end
                    end
                    SVC_DELETE:
                    begin
                        next_st.rsp.ok = 1'b1;
                        next_st.conn   = CS_NONE;
                        next_st.prod   = '0;
                        trigLoad = 1'b0;
                        wdLoad   = 1'b0;
                        inhLoad  = 1'b0;
                        trigStop = 1'b1;
                        wdStop   = 1'b1;
                        inhStop  = 1'b1;
                    end
                    SVC_APPLY:
                    begin
                        if (st.conn != CS_CONFIG)
                            next_st.rsp.ok = 1'b0;
                        else if (st.rate != 16'h0000 && st.rate < st.gap)
                            next_st.rsp.data = `APPLY_ERR_INHIBIT;
                        else
                        begin
                            next_st.rsp.ok   = 1'b1;
                            next_st.rsp.data = {outbound_conn_identifier,
                                                inbound_conn_identifier};
                            next_st.applyOut = 1'b1;
                            next_st.conn     = CS_ESTAB;
                            trigLoad = 1'b1;
                            wdLoad   = consumer && st.rate != 16'h0000;
                            wdVal    = wdFirst(st.rate);
                        end
                    end
                    default:
                        next_st.rsp.ok = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st       <= '0;
            st.conn  <= CS_NONE;
            st.toAct <= `TOACT_DEFAULT;
        end
        else
            st <= next_st;
    end

    assign svcRsp        = st.rsp;
    assign applyToApp    = st.applyOut;
    assign prodOut       = st.prod;
    assign rxProcess     = st.rxProc;
    assign timeoutEvent  = st.toEvt;
    assign connState     = st.conn;
    assign inhibitActive = inhRun;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_trig_send: assert property (
        st.conn == CS_ESTAB && trigExp && !produceReq && !retryReq && !svcReq.valid
        && !(wdExp && st.toAct == `TOACT_AUTO_DEL)
        |=> prodOut.trigger && trigCount == $past(st.rate))
        else $error("trigger expiry did not produce");
    a_wd_first: assert property (
        st.conn == CS_CONFIG ##1 st.conn == CS_ESTAB && consumer && st.rate != 16'h0000
        |-> wdCount >= WD_W'(`WD_FIRST_MS) && wdCount >= WD_W'(st.rate) * WD_W'(`WD_RATE_MULT)
        && (wdCount == WD_W'(`WD_FIRST_MS) || wdCount == WD_W'(st.rate) * WD_W'(`WD_RATE_MULT)))
        else $error("first watchdog load wrong");
    a_wd_rearm: assert property (
        st.conn == CS_ESTAB && consumeValid && consumer && !wdExp && !svcReq.valid
        && st.rate != 16'h0000 |=> wdCount == WD_W'(st.rate) * WD_W'(`WD_RATE_MULT))
        else $error("watchdog not restarted on consumption");
    a_rx_after: assert property (
        st.conn == CS_ESTAB && consumeValid |=> rxProcess)
        else $error("processing not released after restart");
    a_wd_zero: assert property (
        (st.rate == 16'h0000 && !wdExp)[*2] |-> !wdRun)
        else $error("watchdog runs with zero rate");
    a_wd_expire: assert property (
        st.conn == CS_ESTAB && wdExp && st.toAct == `TOACT_HOLD && !svcReq.valid
        |=> timeoutEvent && connState == CS_TIMEDOUT)
        else $error("timeout not signalled or held");
    a_inh_start: assert property (
        st.conn == CS_ESTAB && produceReq && !inhRun && !isServer
        && st.gap != 16'h0000 && !svcReq.valid && !(wdExp && st.toAct == `TOACT_AUTO_DEL)
        |=> inhCount == $past(st.gap))
        else $error("inhibit timer not loaded");
    a_inh_block: assert property (
        produceReq && inhRun |=> !prodOut.newData)
        else $error("new data produced while inhibited");
    a_reset_back: assert property (
        st.conn == CS_TIMEDOUT && svcReq.valid && svcReq.code == SVC_RESET
        |=> connState == CS_ESTAB
        && (wdCount == WD_W'(st.rate) * WD_W'(`WD_RATE_MULT) || !consumer))
        else $error("reset did not re-establish");
    a_delete_all: assert property (
        st.conn != CS_NONE && svcReq.valid && svcReq.code == SVC_DELETE
        |=> connState == CS_NONE && !wdRun && !trigRun && !inhRun)
        else $error("delete left timers running");
endmodule

//--- tb/remote_endpoint.sv
// far-side end-point model: answers each production with a consumed message
`timescale 1ns/10ps
module remote_endpoint
    import conn_timing_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      sys_rst,
    input  wire prod_out_t prodOut,
    input  wire logic      ackOn,
    output logic           consumeValid
);
    // fixed four-cycle turnaround; answers are lost while ackOn is low
    logic [3:0] dly;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            dly <= 4'h0;
        else
            dly <= {dly[2:0], prodOut.newData | prodOut.trigger | prodOut.retry};
    end
    assign consumeValid = dly[3] & ackOn;
endmodule

//--- tb/test_connection_timing_supervisor.sv
// self-checking bench for the connection timing supervisor
`timescale 1ns/10ps
`include "conn_timing_consts.svh"
`define CHK(nm, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module test_connection_timing_supervisor
    import conn_timing_pkg::*;
;
    localparam int CPM = 10;
    logic        clk, sys_rst, isServer, produceReq, retryReq, ackOn, rxSeen, hit;
    logic        applyToApp, consumeValid, rxProcess, timeoutEvent, inhibitActive;
    logic [3:0]  transport_class_select;
    logic [15:0] outboundId, inboundId, rate;
    svc_req_t    svcReq;
    svc_rsp_t    svcRsp;
    prod_out_t   prodOut;
    conn_state_t connState;
    logic [32:0] expQ[$];
    int          fail_count, tests_run, seed, applyCnt;

    connection_timing_supervisor #(.CYC_PER_MS(CPM), .WD_W(18)) connection_timing_supervisor_inst (
        .clk(clk), .sys_rst(sys_rst), .isServer(isServer),
        .transport_class_select(transport_class_select),
        .outbound_conn_identifier(outboundId), .inbound_conn_identifier(inboundId),
        .svcReq(svcReq), .svcRsp(svcRsp), .applyToApp(applyToApp),
        .produceReq(produceReq), .retryReq(retryReq), .consumeValid(consumeValid),
        .prodOut(prodOut), .rxProcess(rxProcess), .timeoutEvent(timeoutEvent),
        .connState(connState), .inhibitActive(inhibitActive));
    remote_endpoint remote_endpoint_inst (.clk(clk), .sys_rst(sys_rst), .prodOut(prodOut),
        .ackOn(ackOn), .consumeValid(consumeValid));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic stop_test();
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // drivers and monitor
    // ----------------------------------------
    task automatic svc(input svc_code_t c, input logic [7:0] a, input logic [15:0] d,
                       input logic ok, input logic [31:0] rd);
        @(posedge clk);
        svcReq <= '{1'b1, c, a, d};
        expQ.push_back({ok, rd});
        @(posedge clk);
        svcReq <= '0;
        @(posedge clk);
        #1;
    endtask

    task automatic prod(input logic p, input logic r);
        @(posedge clk);
        produceReq <= p;
        retryReq <= r;
        @(posedge clk);
        produceReq <= 1'b0;
        retryReq <= 1'b0;
        #1;
    endtask

    // ev bits: 0 timeout, 1 blocked, 2 trigger, 3 retry, 4 newData, 5 inhibit over
    task automatic waitEv(input int idx, input int lim);
        logic [5:0] ev;
        int         n;
        hit = 1'b0;
        n = 0;
        while (hit !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            #1;
            ev = {~inhibitActive, prodOut.newData, prodOut.retry, prodOut.trigger,
                  prodOut.blocked, timeoutEvent};
            hit = ev[idx];
            n++;
        end
    endtask

    always @(posedge clk)
    begin : mon
        logic [32:0] e;
        if (sys_rst === 1'b1)
        begin
            rxSeen   <= 1'b0;
            applyCnt <= 0;
        end
        else
        begin
            if (rxProcess === 1'b1)
                rxSeen <= 1'b1;
            if (applyToApp === 1'b1)
                applyCnt <= applyCnt + 1;
        end
        if (svcRsp.valid === 1'b1)
        begin
            e = 'x;
            if (expQ.size() > 0)
                e = expQ.pop_front();
            `CHK("svcRsp", e, {svcRsp.ok, svcRsp.data})
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        seed = 32'h7DBE3B9F;
        {sys_rst, isServer, produceReq, retryReq, ackOn} = 5'b10001;
        transport_class_select = `CLASS_2;
        svcReq = '0;
        fail_count = 0;
        tests_run = 0;
        rate = 16'h0003 + 16'($random(seed) & 3);
        outboundId = 16'($random(seed));
        inboundId = 16'($random(seed));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("state", CS_NONE, connState)
        svc(SVC_GET, `ATTR_PACKET_RATE, 16'h0, 1'b0, 32'h0);
        svc(SVC_CREATE, 8'h00, 16'h0, 1'b1, 32'h0);
        svc(SVC_SET, `ATTR_PACKET_RATE, rate, 1'b1, {16'h0, rate});
        svc(SVC_SET, `ATTR_INHIBIT, rate + 16'h1, 1'b1, {16'h0, rate + 16'h1});
        svc(SVC_APPLY, 8'h00, 16'h0, 1'b0, `APPLY_ERR_INHIBIT);
        svc(SVC_SET, `ATTR_INHIBIT, 16'h2, 1'b1, 32'h2);
        svc(SVC_GET, `ATTR_INHIBIT, 16'h0, 1'b1, 32'h2);
        svc(SVC_SET, `ATTR_TIMEOUT_ACT, 16'h3, 1'b0, 32'h0);
        svc(SVC_SET, `ATTR_TIMEOUT_ACT, 16'(`TOACT_AUTO_RST), 1'b1, 32'h0);
        svc(SVC_GET, `ATTR_TIMEOUT_ACT, 16'h0, 1'b1, 32'h2);
        svc(SVC_GET, `ATTR_PACKET_RATE, 16'h0, 1'b1, {16'h0, rate});
        svc(SVC_APPLY, 8'h00, 16'h0, 1'b1, {outboundId, inboundId});
        `CHK("state", CS_ESTAB, connState)
        svc(SVC_GET, `ATTR_STATE, 16'h0, 1'b1, 32'h4);
        @(posedge clk);
        produceReq <= 1'b1;
        @(posedge clk);
        #1;
        `CHK("newData", 1'b1, prodOut.newData)
        `CHK("inhibit", 1'b1, inhibitActive)
        @(posedge clk);
        produceReq <= 1'b0;
        #1;
        `CHK("blocked", 1'b1, prodOut.blocked)
        prod(1'b0, 1'b1);
        `CHK("retry", 1'b1, prodOut.retry)
        waitEv(5, 2 * CPM + 20);
        `CHK("inhibitEnd", 1'b1, hit)
        prod(1'b1, 1'b0);
        `CHK("newData", 1'b1, prodOut.newData)
        waitEv(2, rate * CPM + 30);
        `CHK("trigger", 1'b1, hit)
        `CHK("rxProcess", 1'b1, rxSeen)
        @(posedge clk);
        ackOn <= 1'b0;
        waitEv(0, 4 * rate * CPM + 40);
        `CHK("timeout", 1'b1, hit)
        `CHK("state", CS_ESTAB, connState)
        svc(SVC_SET, `ATTR_TIMEOUT_ACT, 16'(`TOACT_HOLD), 1'b1, 32'h0);
        waitEv(0, 4 * rate * CPM + 40);
        `CHK("timeout", 1'b1, hit)
        repeat (2) @(posedge clk);
        `CHK("state", CS_TIMEDOUT, connState)
        svc(SVC_RESET, 8'h00, 16'h0, 1'b1, 32'h0);
        `CHK("state", CS_ESTAB, connState)
        svc(SVC_SET, `ATTR_TIMEOUT_ACT, 16'(`TOACT_AUTO_DEL), 1'b1, 32'h0);
        waitEv(0, 4 * rate * CPM + 40);
        `CHK("timeout", 1'b1, hit)
        repeat (2) @(posedge clk);
        `CHK("state", CS_NONE, connState)
        svc(SVC_CREATE, 8'h00, 16'h0, 1'b1, 32'h0);
        svc(SVC_DELETE, 8'h00, 16'h0, 1'b1, 32'h0);
        `CHK("state", CS_NONE, connState)
        // server end: consumes, but never runs the inhibit timer
        @(posedge clk);
        isServer <= 1'b1;
        transport_class_select <= 4'h0;
        svc(SVC_CREATE, 8'h00, 16'h0, 1'b1, 32'h0);
        svc(SVC_SET, `ATTR_INHIBIT, 16'h1, 1'b1, 32'h1);
        svc(SVC_SET, `ATTR_PACKET_RATE, rate, 1'b1, {16'h0, rate});
        svc(SVC_APPLY, 8'h00, 16'h0, 1'b1, {outboundId, inboundId});
        prod(1'b1, 1'b0);
        `CHK("newData", 1'b1, prodOut.newData)
        `CHK("serverInhibit", 1'b0, inhibitActive)
        `CHK("apply", 2, applyCnt)
        stop_test();
    end
endmodule
